/* File: include/pae_pkg.sv */
/*
 * Shared constants and types for the process alarm evaluator.
 * Assumes a single 100 MHz core clock; values are signed fixed-point counts.
 */
package pae_pkg;
  localparam int VAL_W = 16;
  localparam int TYPE_W = 5;
  localparam logic [TYPE_W-1:0] TYPE_OFF = 5'h00;
  localparam logic [TYPE_W-1:0] TYPE_BAND_OUT = 5'h01;
  localparam logic [TYPE_W-1:0] TYPE_DEV_HI = 5'h02;
  localparam logic [TYPE_W-1:0] TYPE_DEV_LO = 5'h03;
  localparam logic [TYPE_W-1:0] TYPE_BAND_IN = 5'h04;
  localparam logic [TYPE_W-1:0] TYPE_BAND_OUT_SB = 5'h05;
  localparam logic [TYPE_W-1:0] TYPE_DEV_HI_SB = 5'h06;
  localparam logic [TYPE_W-1:0] TYPE_DEV_LO_SB = 5'h07;
  localparam logic [TYPE_W-1:0] TYPE_ABS_HI = 5'h08;
  localparam logic [TYPE_W-1:0] TYPE_ABS_LO = 5'h09;
  localparam logic [TYPE_W-1:0] TYPE_ABS_HI_SB = 5'h0a;
  localparam logic [TYPE_W-1:0] TYPE_ABS_LO_SB = 5'h0b;
  localparam logic [TYPE_W-1:0] TYPE_LOOP_BREAK = 5'h0c;
  localparam logic [TYPE_W-1:0] TYPE_RATE = 5'h0d;
  localparam logic [TYPE_W-1:0] TYPE_SP_HI = 5'h0e;
  localparam logic [TYPE_W-1:0] TYPE_SP_LO = 5'h0f;
  localparam logic [TYPE_W-1:0] TYPE_MV_HI = 5'h10;
  localparam logic [TYPE_W-1:0] TYPE_MV_LO = 5'h11;
  localparam logic [TYPE_W-1:0] TYPE_RESET = TYPE_DEV_HI;
  localparam int DELAY_W = 10;
  localparam int DELAY_MAX_S = 999;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_CYCLES = CLK_HZ;
endpackage

/* File: src/pae_delay.sv */
/*
 * One alarm channel's on/off delay stage, counted in seconds.
 * Assumes a one-cycle second tick from the top and a synchronised active-low reset copy, applied asynchronously.
 */
module pae_delay (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Timing
  input wire logic sec_tick_i,
  input wire logic [pae_pkg::DELAY_W-1:0] on_delay_i,
  input wire logic [pae_pkg::DELAY_W-1:0] off_delay_i,
  // Alarm
  input wire logic raw_i,
  output logic out_o
);
  typedef struct packed {
    logic out;
    logic [pae_pkg::DELAY_W-1:0] cnt;
  } pae_dly_type;

  pae_dly_type state_reg;
  pae_dly_type state_next;

  always_comb begin
    logic [pae_pkg::DELAY_W-1:0] lim;
    lim = state_reg.out ? off_delay_i : on_delay_i;
    state_next = state_reg;
    // The output follows the raw alarm once it has differed through as many second ticks as the delay.
    if (raw_i == state_reg.out) begin
      state_next.cnt = '0;
    end else if (lim == '0) begin
      state_next.out = raw_i;
      state_next.cnt = '0;
    end else if (sec_tick_i) begin
      if (state_reg.cnt + 10'h001 >= lim) begin
        state_next.out = raw_i;
        state_next.cnt = '0;
      end else begin
        state_next.cnt = state_reg.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign out_o = state_reg.out;

  AST_ZERO_DELAY_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (raw_i && !out_o && on_delay_i == '0) |=> out_o)
    else $error("Zero on-delay did not pass the alarm at once.");
  AST_NO_EARLY_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!out_o && !sec_tick_i && on_delay_i != '0) |=> !out_o)
    else $error("Alarm turned on without a second tick.");
endmodule

/* File: src/pae_top.sv */
/*
 * Process alarm evaluator: per-channel alarm type decode, hysteresis,
 * standby sequence, on/off delay and auxiliary output assignment.
 * Assumes the process value, set point and manipulated variables are synchronous
 * to core_clk_i; the control start input is an asynchronous pin.
 */
module pae_top #(
  parameter int CHANNELS = 4,
  parameter int OUTPUTS = 3,
  parameter int SEC_CYCLES = pae_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Loop values
  input wire logic signed [pae_pkg::VAL_W-1:0] process_value_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] set_point_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] manipulated_variable_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] cool_manipulated_variable_i,
  input wire logic heat_cool_mode_i,
  input wire logic heater_alarm_i,
  input wire logic heater_fitted_i,
  input wire logic control_start_i,
  // Channel configuration, one slice per channel
  input wire logic [CHANNELS-1:0] type_write_i,
  input wire logic [CHANNELS*pae_pkg::TYPE_W-1:0] type_wdata_i,
  input wire logic [CHANNELS*pae_pkg::VAL_W-1:0] alarm_value_i,
  input wire logic [CHANNELS*pae_pkg::VAL_W-1:0] lower_value_i,
  input wire logic [CHANNELS*pae_pkg::VAL_W-1:0] hysteresis_i,
  input wire logic [CHANNELS*pae_pkg::DELAY_W-1:0] on_delay_i,
  input wire logic [CHANNELS*pae_pkg::DELAY_W-1:0] off_delay_i,
  // Output assignment: per output, channel index plus enable bit
  input wire logic [OUTPUTS*($clog2(CHANNELS)+1)-1:0] out_assign_i,
  // Results
  output logic [CHANNELS*pae_pkg::TYPE_W-1:0] type_o,
  output logic [CHANNELS-1:0] alarm_o,
  output logic [CHANNELS-1:0] type_reject_o,
  output logic channel1_type_visible_o,
  output logic [OUTPUTS-1:0] aux_out_o
);
  localparam int SEL_W = $clog2(CHANNELS);
  localparam int W = pae_pkg::VAL_W;
  localparam int CNT_W = $clog2(SEC_CYCLES + 1);

  typedef struct packed {
    logic [1:0] start_sync;
    logic start_seen;
    logic [CNT_W-1:0] div;
    logic sec_tick;
    logic [CHANNELS*pae_pkg::TYPE_W-1:0] types;
    logic [CHANNELS-1:0] raw;
    logic [CHANNELS-1:0] armed;
    logic [CHANNELS-1:0] reject;
    logic ch1_visible;
    logic [OUTPUTS-1:0] aux;
  } pae_state_type;

  pae_state_type state_reg;
  pae_state_type state_next;
  logic rst_n;
  logic [CHANNELS-1:0] delayed;
  // The reset synchroniser has its own asynchronous reset, so it lives outside the struct.
  logic [1:0] rst_sync_reg;

  assign rst_n = rst_sync_reg[1];

  // Extend by one bit so set point plus deviation never wraps.
  function automatic logic signed [W:0] ext(input logic [W-1:0] v);
    ext = {v[W-1], v};
  endfunction

  always_comb begin
    logic start_edge;
    logic [pae_pkg::TYPE_W-1:0] ty;
    logic [pae_pkg::TYPE_W-1:0] base;
    logic signed [W:0] pv;
    logic signed [W:0] sp;
    logic signed [W:0] x;
    logic signed [W:0] lo;
    logic signed [W:0] hy;
    logic signed [W:0] hi_th;
    logic signed [W:0] lo_th;
    logic signed [W:0] mon;
    logic on_cond;
    logic off_cond;
    logic standby;
    logic [SEL_W:0] asg;
    state_next = state_reg;
    start_edge = 1'b0;
    ty = '0;
    base = '0;
    pv = ext(process_value_i);
    sp = ext(set_point_i);
    x = '0;
    lo = '0;
    hy = '0;
    hi_th = '0;
    lo_th = '0;
    mon = '0;
    on_cond = 1'b0;
    off_cond = 1'b0;
    standby = 1'b0;
    asg = '0;
    state_next.start_sync = {state_reg.start_sync[0], control_start_i};
    state_next.start_seen = state_reg.start_sync[1];
    start_edge = state_reg.start_sync[1] && !state_reg.start_seen;
    // One-second enable for the delay stages.
    state_next.sec_tick = 1'b0;
    if (state_reg.div == CNT_W'(SEC_CYCLES - 1)) begin
      state_next.div = '0;
      state_next.sec_tick = 1'b1;
    end else begin
      state_next.div = state_reg.div + CNT_W'(1);
    end
    // Channel 1's type stays hidden on heater variants until assigned to an output.
    state_next.ch1_visible = !heater_fitted_i;
    for (int o = 0; o < OUTPUTS; o++) begin
      asg = out_assign_i[o*(SEL_W+1) +: (SEL_W+1)];
      if (asg[SEL_W] && asg[SEL_W-1:0] == '0) begin
        state_next.ch1_visible = 1'b1;
      end
    end
    for (int c = 0; c < CHANNELS; c++) begin
      state_next.reject[c] = 1'b0;
      if (type_write_i[c]) begin
        ty = type_wdata_i[c*pae_pkg::TYPE_W +: pae_pkg::TYPE_W];
        if (ty > pae_pkg::TYPE_MV_LO || (ty == pae_pkg::TYPE_LOOP_BREAK && c != 0) ||
            (c == 0 && !state_reg.ch1_visible)) begin
          state_next.reject[c] = 1'b1;
        end else begin
          state_next.types[c*pae_pkg::TYPE_W +: pae_pkg::TYPE_W] = ty;
        end
      end
      ty = state_reg.types[c*pae_pkg::TYPE_W +: pae_pkg::TYPE_W];
      x = ext(alarm_value_i[c*W +: W]);
      lo = ext(lower_value_i[c*W +: W]);
      hy = ext(hysteresis_i[c*W +: W]);
      // Standby types share the comparison of their plain counterparts.
      case (ty)
        pae_pkg::TYPE_BAND_OUT_SB: base = pae_pkg::TYPE_BAND_OUT;
        pae_pkg::TYPE_DEV_HI_SB: base = pae_pkg::TYPE_DEV_HI;
        pae_pkg::TYPE_DEV_LO_SB: base = pae_pkg::TYPE_DEV_LO;
        pae_pkg::TYPE_ABS_HI_SB: base = pae_pkg::TYPE_ABS_HI;
        pae_pkg::TYPE_ABS_LO_SB: base = pae_pkg::TYPE_ABS_LO;
        default: base = ty;
      endcase
      standby = (ty == pae_pkg::TYPE_BAND_OUT_SB) || (ty == pae_pkg::TYPE_DEV_HI_SB) ||
                (ty == pae_pkg::TYPE_DEV_LO_SB) || (ty == pae_pkg::TYPE_ABS_HI_SB) ||
                (ty == pae_pkg::TYPE_ABS_LO_SB);
      // Upper and lower limits held separately for band types.
      hi_th = sp + x;
      lo_th = sp - lo;
      case (base)
        pae_pkg::TYPE_BAND_OUT: begin
          on_cond = pv > hi_th || pv < lo_th;
          off_cond = pv <= hi_th - hy && pv >= lo_th + hy;
        end
        pae_pkg::TYPE_BAND_IN: begin
          on_cond = pv >= lo_th && pv <= hi_th;
          off_cond = pv < lo_th - hy || pv > hi_th + hy;
        end
        pae_pkg::TYPE_DEV_HI: begin
          on_cond = pv >= sp + x;
          off_cond = pv < sp + x - hy;
        end
        pae_pkg::TYPE_DEV_LO: begin
          on_cond = pv <= sp - x;
          off_cond = pv > sp - x + hy;
        end
        pae_pkg::TYPE_ABS_HI, pae_pkg::TYPE_SP_HI, pae_pkg::TYPE_MV_HI: begin
          mon = (base == pae_pkg::TYPE_ABS_HI) ? pv :
                (base == pae_pkg::TYPE_SP_HI) ? sp : ext(manipulated_variable_i);
          on_cond = mon > x;
          off_cond = mon <= x - hy;
          if (base == pae_pkg::TYPE_MV_HI && heat_cool_mode_i && x < 0) begin
            on_cond = 1'b1;
            off_cond = 1'b0;
          end
        end
        pae_pkg::TYPE_ABS_LO, pae_pkg::TYPE_SP_LO, pae_pkg::TYPE_MV_LO: begin
          mon = (base == pae_pkg::TYPE_ABS_LO) ? pv :
                (base == pae_pkg::TYPE_SP_LO) ? sp :
                (heat_cool_mode_i ? ext(cool_manipulated_variable_i) :
                 ext(manipulated_variable_i));
          on_cond = mon < x;
          off_cond = mon >= x + hy;
          if (base == pae_pkg::TYPE_MV_LO && heat_cool_mode_i && x < 0) begin
            on_cond = 1'b1;
            off_cond = 1'b0;
          end
        end
        default: begin
          on_cond = 1'b0;
          off_cond = 1'b1;
        end
      endcase
      if (c == 0 && heater_fitted_i && !state_reg.ch1_visible) begin
        on_cond = heater_alarm_i;
        off_cond = !heater_alarm_i;
      end
      // Hysteresis: hold the alarm until the release threshold is crossed.
      if (on_cond) begin
        state_next.raw[c] = 1'b1;
      end else if (off_cond || !state_reg.raw[c]) begin
        state_next.raw[c] = 1'b0;
      end
      if (ty == pae_pkg::TYPE_BAND_OUT_SB && (hi_th - hy) < (lo_th + hy)) begin
        state_next.raw[c] = 1'b0;
      end
      // Standby: disarmed on control start or type change, armed once outside alarm.
      if (start_edge || type_write_i[c]) begin
        state_next.armed[c] = 1'b0;
      end else if (!on_cond) begin
        state_next.armed[c] = 1'b1;
      end
      if (standby && !state_reg.armed[c]) begin
        state_next.raw[c] = 1'b0;
      end
    end
    for (int o = 0; o < OUTPUTS; o++) begin
      asg = out_assign_i[o*(SEL_W+1) +: (SEL_W+1)];
      state_next.aux[o] = asg[SEL_W] && delayed[asg[SEL_W-1:0]];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.start_sync <= 2'h0;
      state_reg.start_seen <= 1'b0;
      state_reg.div <= '0;
      state_reg.sec_tick <= 1'b0;
      state_reg.types <= {CHANNELS{pae_pkg::TYPE_RESET}};
      state_reg.raw <= '0;
      state_reg.armed <= '0;
      state_reg.reject <= '0;
      state_reg.ch1_visible <= 1'b0;
      state_reg.aux <= '0;
    end else begin
      state_reg.start_sync <= state_next.start_sync;
      state_reg.start_seen <= state_next.start_seen;
      state_reg.div <= state_next.div;
      state_reg.sec_tick <= state_next.sec_tick;
      state_reg.types <= state_next.types;
      state_reg.raw <= state_next.raw;
      state_reg.armed <= state_next.armed;
      state_reg.reject <= state_next.reject;
      state_reg.ch1_visible <= state_next.ch1_visible;
      state_reg.aux <= state_next.aux;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_dly
    pae_delay u_delay (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .sec_tick_i(state_reg.sec_tick),
      .on_delay_i(on_delay_i[c*pae_pkg::DELAY_W +: pae_pkg::DELAY_W]),
      .off_delay_i(off_delay_i[c*pae_pkg::DELAY_W +: pae_pkg::DELAY_W]),
      .raw_i(state_reg.raw[c]),
      .out_o(delayed[c])
    );
  end

  assign type_o = state_reg.types;
  assign alarm_o = delayed;
  assign type_reject_o = state_reg.reject;
  assign channel1_type_visible_o = state_reg.ch1_visible;
  assign aux_out_o = state_reg.aux;

  AST_RESET_TYPE: assert property (@(posedge core_clk_i)
    $rose(rst_n) |-> type_o[pae_pkg::TYPE_W-1:0] == pae_pkg::TYPE_DEV_HI)
    else $error("Channel type not at upper-limit default after reset.");
  AST_LBA_REJECT: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (type_write_i[CHANNELS-1] &&
     type_wdata_i[(CHANNELS-1)*pae_pkg::TYPE_W +: pae_pkg::TYPE_W] == pae_pkg::TYPE_LOOP_BREAK)
    |=> type_reject_o[CHANNELS-1] && $stable(type_o))
    else $error("Loop break type accepted on a channel other than one.");
  AST_DEV_HI_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (type_o[pae_pkg::TYPE_W-1:0] == pae_pkg::TYPE_DEV_HI && !heater_fitted_i &&
     ext(process_value_i) >= ext(set_point_i) + ext(alarm_value_i[W-1:0]))
    |=> state_reg.raw[0])
    else $error("Deviation upper-limit alarm failed to assert.");
  AST_ABS_LO_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (type_o[pae_pkg::TYPE_W-1:0] == pae_pkg::TYPE_ABS_LO && !heater_fitted_i &&
     $signed(process_value_i) >= $signed(alarm_value_i[W-1:0]) + $signed(hysteresis_i[W-1:0]))
    |=> !state_reg.raw[0])
    else $error("Absolute lower-limit alarm held past its release point.");
  AST_AUX_ROUTE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !out_assign_i[SEL_W] |=> !aux_out_o[0])
    else $error("Unassigned auxiliary output driven.");
endmodule

/* File: sim/pae_loop_model.sv */
/*
 * Loop-side partner of the alarm evaluator: the source of the process value,
 * set point and both manipulated variables.
 * Assumes the bench sets target values; they reach the pins only at a falling clock edge.
 */
module pae_loop_model (
  // Clock
  input wire logic core_clk_i,
  // Targets from the bench
  input wire logic signed [pae_pkg::VAL_W-1:0] pv_target_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] sp_target_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] mv_target_i,
  input wire logic signed [pae_pkg::VAL_W-1:0] cool_mv_target_i,
  // Loop values
  output logic signed [pae_pkg::VAL_W-1:0] process_value_o,
  output logic signed [pae_pkg::VAL_W-1:0] set_point_o,
  output logic signed [pae_pkg::VAL_W-1:0] manipulated_variable_o,
  output logic signed [pae_pkg::VAL_W-1:0] cool_manipulated_variable_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A real loop refreshes its values once per sample, never mid-edge, so updates land here.
  always @(negedge core_clk_i) begin
    process_value_o <= pv_target_i;
    set_point_o <= sp_target_i;
    manipulated_variable_o <= mv_target_i;
    cool_manipulated_variable_o <= cool_mv_target_i;
  end
endmodule

/* File: sim/tb_top.sv */
/*
 * Self-checking bench for the process alarm evaluator.
 * Assumes the loop model above supplies the loop values; a second lasts SECS clock cycles.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SECS = 10;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic signed [15:0] pv_t = '0, sp_t = '0, mv_t = '0, cmv_t = '0;
  logic signed [15:0] pv, sp, mv, cmv;
  logic heat_cool = 1'b0, heater_alarm = 1'b0, heater_fitted = 1'b0, control_start = 1'b0;
  logic [3:0] twr = '0;
  logic [19:0] twd = '0;
  logic [63:0] xv = '0, lv = '0, hy = '0;
  logic [39:0] ond = '0, ofd = '0;
  logic [8:0] oas = 9'h144;
  logic [19:0] type_o;
  logic [3:0] alarm, rej;
  logic vis;
  logic [2:0] aux;
  int err_count = 0;
  int cmp_count = 0;
  int n;

  always #5 core_clk = ~core_clk;

  pae_loop_model model (.core_clk_i(core_clk), .pv_target_i(pv_t), .sp_target_i(sp_t),
    .mv_target_i(mv_t), .cool_mv_target_i(cmv_t), .process_value_o(pv), .set_point_o(sp),
    .manipulated_variable_o(mv), .cool_manipulated_variable_o(cmv));

  pae_top #(.CHANNELS(4), .OUTPUTS(3), .SEC_CYCLES(SECS)) uut (.core_clk_i(core_clk),
    .resetn_i(resetn), .process_value_i(pv), .set_point_i(sp), .manipulated_variable_i(mv),
    .cool_manipulated_variable_i(cmv), .heat_cool_mode_i(heat_cool),
    .heater_alarm_i(heater_alarm), .heater_fitted_i(heater_fitted),
    .control_start_i(control_start), .type_write_i(twr), .type_wdata_i(twd),
    .alarm_value_i(xv), .lower_value_i(lv), .hysteresis_i(hy), .on_delay_i(ond),
    .off_delay_i(ofd), .out_assign_i(oas), .type_o(type_o), .alarm_o(alarm),
    .type_reject_o(rej), .channel1_type_visible_o(vis), .aux_out_o(aux));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // A refused write must leave the previous type in place.
  task automatic wr_type(input int c, input logic [4:0] code, input logic rexp);
    logic [4:0] old;
    old = type_o[c*5 +: 5];
    twd[c*5 +: 5] = code;
    twr[c] = 1'b1;
    cyc(1);
    twr = '0;
    chk("type reject", 20'(rexp), 20'(rej[c]));
    chk("type", 20'(rexp ? old : code), 20'(type_o[c*5 +: 5]));
    // Let an edge pass so that a following write raises its strobe afresh.
    cyc(1);
  endtask

  task automatic cfg(input int c, input logic [4:0] code, input logic signed [15:0] x, l, h);
    xv[c*16 +: 16] = x;
    lv[c*16 +: 16] = l;
    hy[c*16 +: 16] = h;
    wr_type(c, code, 1'b0);
  endtask

  // Output 0 carries channel 0, output 2 channel 1, output 1 is unassigned.
  task automatic at(input int c, input int sel, input logic signed [15:0] v, input logic e);
    case (sel)
      0: pv_t = v;
      1: sp_t = v;
      2: mv_t = v;
      default: cmv_t = v;
    endcase
    cyc(8);
    chk("alarm", 20'(e), 20'(alarm[c]));
    if (c < 2) chk("aux", 20'(e), 20'(aux[c*2]));
    chk("aux unassigned", 20'h0, 20'(aux[1]));
  endtask

  task automatic trio(input logic [4:0] code, input int sel, input logic signed [15:0] x, a, b, d);
    cfg(0, code, x, 16'sh0, 16'sh0);
    at(0, sel, a, 1'b0);
    at(0, sel, b, 1'b1);
    at(0, sel, d, 1'b0);
  endtask

  task automatic wait_alarm(input logic e, output int k);
    k = 0;
    while (alarm[0] !== e) begin
      cyc(1);
      k++;
      if (k > 60) begin
        $display("BAD alarm wait expected %h seen %h", e, alarm[0]);
        err_count++;
        finish_test();
      end
    end
  endtask

  initial begin
    cyc(2);
    resetn = 1'b1;
    cyc(6);
    chk("reset types", {4{5'h02}}, type_o);
    chk("visible", 20'h1, 20'(vis));
    sp_t = 16'sd100;
    pv_t = 16'sd100;
    trio(5'h02, 0, 16'sd10, 16'sd109, 16'sd110, 16'sd100);
    trio(5'h03, 0, 16'sd10, 16'sd91, 16'sd90, 16'sd100);
    cfg(0, 5'h01, 16'sd10, 16'sd5, 16'sh0);
    at(0, 0, 16'sd111, 1'b1);
    at(0, 0, 16'sd110, 1'b0);
    at(0, 0, 16'sd95, 1'b0);
    at(0, 0, 16'sd94, 1'b1);
    cfg(0, 5'h04, 16'sd10, 16'sd5, 16'sh0);
    at(0, 0, 16'sd100, 1'b1);
    at(0, 0, 16'sd111, 1'b0);
    at(0, 0, 16'sd94, 1'b0);
    trio(5'h08, 0, 16'sd50, 16'sd50, 16'sd51, 16'sd40);
    trio(5'h09, 0, 16'sd50, 16'sd50, 16'sd49, 16'sd60);
    trio(5'h0e, 1, 16'sd50, 16'sd50, 16'sd51, 16'sd40);
    trio(5'h0f, 1, 16'sd50, 16'sd50, 16'sd49, 16'sd60);
    sp_t = 16'sd100;
    trio(5'h10, 2, 16'sd50, 16'sd50, 16'sd51, 16'sd0);
    trio(5'h11, 2, 16'sd50, 16'sd50, 16'sd49, 16'sd60);
    cfg(0, 5'h08, 16'sd50, 16'sh0, 16'sd5);
    at(0, 0, 16'sd51, 1'b1);
    at(0, 0, 16'sd47, 1'b1);
    at(0, 0, 16'sd40, 1'b0);
    cfg(0, 5'h05, 16'sd2, 16'sd2, 16'sd3);
    // Arm the standby first, so that only the overlap rule can keep the alarm off.
    at(0, 0, 16'sd100, 1'b0);
    at(0, 0, 16'sd150, 1'b0);
    at(0, 0, 16'sd50, 1'b0);
    pv_t = 16'sd120;
    cfg(1, 5'h06, 16'sd10, 16'sh0, 16'sh0);
    at(1, 0, 16'sd120, 1'b0);
    at(1, 0, 16'sd100, 1'b0);
    at(1, 0, 16'sd120, 1'b1);
    control_start = 1'b1;
    at(1, 0, 16'sd120, 1'b0);
    control_start = 1'b0;
    cfg(1, 5'h0a, 16'sd50, 16'sh0, 16'sh0);
    at(1, 0, 16'sd120, 1'b0);
    at(1, 0, 16'sd0, 1'b0);
    at(1, 0, 16'sd120, 1'b1);
    heat_cool = 1'b1;
    mv_t = 16'sd0;
    cmv_t = 16'sd20;
    cfg(0, 5'h11, 16'sd10, 16'sh0, 16'sh0);
    at(0, 3, 16'sd5, 1'b1);
    at(0, 3, 16'sd20, 1'b0);
    cfg(0, 5'h10, 16'sd10, 16'sh0, 16'sh0);
    at(0, 3, 16'sd100, 1'b0);
    at(0, 2, 16'sd20, 1'b1);
    cfg(0, 5'h10, -16'sd5, 16'sh0, 16'sh0);
    at(0, 2, -16'sd100, 1'b1);
    cfg(0, 5'h11, -16'sd5, 16'sh0, 16'sh0);
    at(0, 3, 16'sd100, 1'b1);
    heat_cool = 1'b0;
    wr_type(1, 5'h12, 1'b1);
    wr_type(1, 5'h0c, 1'b1);
    wr_type(0, 5'h0c, 1'b0);
    for (int k = 0; k < 18; k++) begin
      wr_type(3, 5'(k), k == 12);
    end
    cfg(0, 5'h08, 16'sd50, 16'sh0, 16'sh0);
    at(0, 0, 16'sd0, 1'b0);
    ond[9:0] = 10'h002;
    ofd[9:0] = 10'h001;
    pv_t = 16'sd60;
    wait_alarm(1'b1, n);
    chk("on delay", 20'h1, 20'(n > SECS && n <= 2*SECS+8));
    pv_t = 16'sd0;
    wait_alarm(1'b0, n);
    chk("off delay", 20'h1, 20'(n >= 2 && n <= SECS+8));
    ond[9:0] = 10'h3e7;
    pv_t = 16'sd60;
    cyc(300);
    chk("long on delay", 20'h0, 20'(alarm[0]));
    pv_t = 16'sd0;
    cyc(4);
    ond = '0;
    ofd = '0;
    cyc(30);
    heater_fitted = 1'b1;
    oas = '0;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(6);
    chk("visible", 20'h0, 20'(vis));
    wr_type(0, 5'h08, 1'b1);
    heater_alarm = 1'b1;
    cyc(8);
    chk("heater alarm", 20'h1, 20'(alarm[0]));
    oas = 9'h004;
    cyc(8);
    chk("visible", 20'h1, 20'(vis));
    finish_test();
  end
endmodule
